// *** rtl/adc_readout_mode_control.sv ***
// Readout-mode control: control register, compression passes, ECL and crate-bus readout
// What this block does
// - ECL readout subtracts pedestals when bit set
// - Uncompressed ECL sends 16 clamped words, no subaddress
// - ECL compression drops values below 1, 2.5us
// - Empty ECL compression skips to crate readout
// - Header word: flag bit, station id, count
// - Compressed ECL: header first, words carry subaddress
// - ECL disabled: crate readout straight after conversion
// - ECL enabled: crate readout after ECL finishes
// - Crate reads subtract pedestals when bit set
// - Uncompressed crate: 16 clamped words, no subaddress
// - Sequential crate compression 2.5us, empty means none
// - Random access: A selects, Q until clear
// - Sequential: advance at S2 end, Q stop
// - LAM only when enabled and data ready
// - Overflow suppress drops overflows too, 2.5us
// - Z sets all readout and compression bits except overflow suppress
// - ECL words 16 bits, at most 10 MHz
// - Control register access only when ready
// - Low 8 bits are station identifier
`timescale 1ns/10ps
`include "adc_readout_defines.svh"
module adc_readout_mode_control
    import adc_readout_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Dataway
    input wire logic n_in,
    input wire logic [4:0] f_in,
    input wire logic [3:0] a_in,
    input wire logic s1_in,
    input wire logic s2_in,
    input wire logic c_in,
    input wire logic z_in,
    input wire logic [15:0] w_in,
    output logic [15:0] r_out,
    output logic q_out,
    output logic lam_out,
    // Converter and pedestal memory
    input wire logic conv_done_in,
    input wire chan_values_t conv_data_in,
    input wire ped_values_t pedestal_in,
    // ECL port
    output logic [15:0] ecl_data_out,
    output logic ecl_strobe_out,
    output logic ecl_request_out,
    input wire logic ecl_ack_in
);
    readout_state_e state;
    logic [15:0] ctrl;
    chan_values_t raw_q;
    logic [15:0] mask;
    logic header_pending;
    logic compressed;
    logic [3:0] hdr_count;
    logic [5:0] timer;
    logic [1:0] gap;
    logic lam_pending;
    logic s1_q;
    logic s2_q;
    logic seq_advance_armed;

    chan_cond_if ecl_if ();
    chan_cond_if crate_if ();

    function automatic logic [3:0] lowest_set(input logic [15:0] m);
        logic [3:0] idx;
        idx = 4'h0;
        for (int k = 15; k >= 0; k--) begin
            if (m[k]) begin
                idx = 4'(k);
            end
        end
        return idx;
    endfunction

    function automatic logic [4:0] popcount(input logic [15:0] m);
        logic [4:0] n;
        n = 5'h00;
        for (int k = 0; k < 16; k++) begin
            n = n + {4'h0, m[k]};
        end
        return n;
    endfunction

    function automatic word_t build_word(input logic hdr, input logic comp,
                                         input logic [7:0] sid, input logic [3:0] cnt,
                                         input logic [3:0] chan, input logic [10:0] val);
        word_t wd;
        if (hdr) begin
            wd = {1'b1, 3'h0, cnt, sid};
        end else if (comp) begin
            wd = {1'b0, chan, val};
        end else begin
            wd = {5'h00, val};
        end
        return wd;
    endfunction

    // Control fields
    wire logic [7:0] station_identifier = ctrl[`SID_MSB:`SID_LSB];
    wire logic ecl_pedestal_subtract = ctrl[`ECL_SUB_BIT];
    wire logic ecl_compress_enable = ctrl[`ECL_COMP_BIT];
    wire logic ecl_port_enable = ctrl[`ECL_EN_BIT];
    wire logic crate_pedestal_subtract = ctrl[`CRATE_SUB_BIT];
    wire logic crate_compress_enable = ctrl[`CRATE_COMP_BIT];
    wire logic crate_sequential_readout = ctrl[`SEQ_BIT];
    wire logic lam_enable = ctrl[`LAM_EN_BIT];
    wire logic overflow_suppress = ctrl[`OVF_SUP_BIT];
    // Random access forces compression off
    wire logic crate_comp_active = crate_compress_enable && crate_sequential_readout;

    // Conditioner hookup
    assign ecl_if.raw = raw_q;
    assign ecl_if.ped = pedestal_in;
    assign ecl_if.subtract = ecl_pedestal_subtract;
    assign ecl_if.zero_sup = ecl_compress_enable;
    assign ecl_if.ovf_sup = ecl_compress_enable && overflow_suppress;
    assign crate_if.raw = raw_q;
    assign crate_if.ped = pedestal_in;
    assign crate_if.subtract = crate_pedestal_subtract;
    assign crate_if.zero_sup = crate_comp_active;
    assign crate_if.ovf_sup = crate_comp_active && overflow_suppress;

    chan_conditioner u_ecl_cond (
        .bus(ecl_if)
    );
    chan_conditioner u_crate_cond (
        .bus(crate_if)
    );

    // Decoding and selection
    wire logic s1_rise = s1_in && !s1_q;
    wire logic s2_fall = s2_q && !s2_in;
    wire logic clear_any = c_in || z_in;
    wire logic is_ready = (state == ST_READY);
    wire logic ctrl_access = n_in && s1_rise && (a_in == `A_CTRL);
    wire logic do_write = ctrl_access && (f_in == `F_WRITE_CTRL);
    wire logic do_read_ctrl = ctrl_access && (f_in == `F_READ_CTRL);
    wire logic do_read_data = n_in && s1_rise && (f_in == `F_READ_DATA);
    wire logic [3:0] cur_chan = lowest_set(mask);
    wire logic words_left = header_pending || (mask != 16'h0000);
    wire logic timer_done = (timer == 6'(`COMPRESS_CYCLES - 1));
    wire logic ecl_pass_done = timer_done || !ecl_compress_enable;
    wire logic crate_pass_done = timer_done || !crate_comp_active;
    wire logic [15:0] ecl_load_mask = ecl_compress_enable ? ecl_if.keep : 16'hFFFF;
    wire logic [15:0] crate_load_mask = crate_comp_active ? crate_if.keep : 16'hFFFF;
    wire logic [4:0] ecl_keep_total = popcount(ecl_if.keep);
    wire logic [4:0] crate_keep_total = popcount(crate_if.keep);
    // A full set of 16 wraps to a count of 0
    wire logic [3:0] ecl_load_count = ecl_keep_total[3:0];
    wire logic [3:0] crate_load_count = crate_keep_total[3:0];
    wire word_t ecl_word = build_word(header_pending, compressed, station_identifier,
                                      hdr_count, cur_chan, ecl_if.value[cur_chan]);
    wire word_t seq_word = build_word(header_pending, compressed, station_identifier,
                                      hdr_count, cur_chan, crate_if.value[cur_chan]);
    wire word_t random_word = {5'h00, crate_if.value[a_in]};
    wire logic [15:0] next_mask = header_pending ? mask : (mask & (mask - 16'h0001));
    wire logic [15:0] next_ctrl = z_in ? (ctrl | `Z_COMMAND_SET) : w_in;

    // Dataway strobe edges
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else begin
            s1_q <= s1_in;
            s2_q <= s2_in;
        end
    end

    // Control register: Z wins over a write in the same cycle
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl <= `CTRL_RESET;
        end else if (z_in || (do_write && is_ready)) begin
            ctrl <= next_ctrl;
        end
    end

    // LAM follows pending crate data, gated by its enable bit
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lam_out <= 1'b0;
        end else begin
            lam_out <= lam_pending && lam_enable && !clear_any;
        end
    end

    // Dataway answers
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r_out <= 16'h0000;
            q_out <= 1'b0;
            seq_advance_armed <= 1'b0;
        end else begin
            if (s2_fall) begin
                seq_advance_armed <= 1'b0;
            end
            if (do_read_ctrl || do_write) begin
                q_out <= is_ready;
                if (do_read_ctrl && is_ready) begin
                    r_out <= ctrl;
                end
            end else if (do_read_data) begin
                if (state != ST_CRATE_READ) begin
                    q_out <= 1'b0;
                end else if (!crate_sequential_readout) begin
                    q_out <= 1'b1;
                    r_out <= random_word;
                end else begin
                    q_out <= words_left;
                    r_out <= words_left ? seq_word : 16'h0000;
                    seq_advance_armed <= words_left;
                end
            end
        end
    end

    // Readout sequence
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= ST_READY;
            raw_q <= '0;
            mask <= 16'h0000;
            header_pending <= 1'b0;
            compressed <= 1'b0;
            hdr_count <= 4'h0;
            timer <= 6'h00;
            gap <= 2'h0;
            lam_pending <= 1'b0;
            ecl_data_out <= 16'h0000;
            ecl_strobe_out <= 1'b0;
            ecl_request_out <= 1'b0;
        end else if (clear_any) begin
            state <= ST_READY;
            mask <= 16'h0000;
            header_pending <= 1'b0;
            lam_pending <= 1'b0;
            ecl_strobe_out <= 1'b0;
            ecl_request_out <= 1'b0;
        end else begin
            if (gap != 2'h0) begin
                gap <= gap - 2'h1;
            end
            case (state)
                ST_READY: begin
                    timer <= 6'h00;
                    if (conv_done_in) begin
                        raw_q <= conv_data_in;
                        // ECL settings are ignored when the port is off
                        state <= ecl_port_enable ? ST_ECL_COMPRESS : ST_CRATE_COMPRESS;
                    end
                end
                ST_ECL_COMPRESS: begin
                    timer <= timer + 6'h01;
                    if (ecl_pass_done) begin
                        timer <= 6'h00;
                        mask <= ecl_load_mask;
                        header_pending <= ecl_compress_enable;
                        compressed <= ecl_compress_enable;
                        hdr_count <= ecl_load_count;
                        if (ecl_compress_enable && (ecl_if.keep == 16'h0000)) begin
                            state <= ST_CRATE_COMPRESS;
                        end else begin
                            state <= ST_ECL_SEND;
                            ecl_request_out <= 1'b1;
                        end
                    end
                end
                ST_ECL_SEND: begin
                    if (ecl_strobe_out) begin
                        if (ecl_ack_in) begin
                            ecl_strobe_out <= 1'b0;
                            header_pending <= 1'b0;
                            mask <= next_mask;
                            gap <= 2'(`ECL_GAP_CYCLES - 1);
                        end
                    end else if (gap == 2'h0) begin
                        if (words_left) begin
                            ecl_data_out <= ecl_word;
                            ecl_strobe_out <= 1'b1;
                        end else begin
                            ecl_request_out <= 1'b0;
                            timer <= 6'h00;
                            state <= ST_CRATE_COMPRESS;
                        end
                    end
                end
                ST_CRATE_COMPRESS: begin
                    timer <= timer + 6'h01;
                    if (crate_pass_done) begin
                        timer <= 6'h00;
                        mask <= crate_load_mask;
                        header_pending <= crate_comp_active;
                        compressed <= crate_comp_active;
                        hdr_count <= crate_load_count;
                        if (crate_comp_active && (crate_if.keep == 16'h0000)) begin
                            state <= ST_CRATE_EMPTY;
                        end else begin
                            state <= ST_CRATE_READ;
                            lam_pending <= 1'b1;
                        end
                    end
                end
                ST_CRATE_READ: begin
                    if (s2_fall && seq_advance_armed && crate_sequential_readout) begin
                        header_pending <= 1'b0;
                        mask <= next_mask;
                    end
                end
                ST_CRATE_EMPTY: begin
                    lam_pending <= 1'b0;
                end
                default: begin
                    state <= ST_READY;
                end
            endcase
        end
    end
endmodule // adc_readout_mode_control

// *** inc/adc_readout_defines.svh ***
// Offsets, field positions, reset values and timing counts of the readout-mode control
`ifndef ADC_READOUT_DEFINES_SVH
`define ADC_READOUT_DEFINES_SVH

// Control register fields (bit index = dataway W line number minus one)
`define SID_LSB 0
`define SID_MSB 7
`define ECL_SUB_BIT 8
`define ECL_COMP_BIT 9
`define ECL_EN_BIT 10
`define CRATE_SUB_BIT 11
`define CRATE_COMP_BIT 12
`define SEQ_BIT 13
`define LAM_EN_BIT 14
`define OVF_SUP_BIT 15
`define CTRL_RESET 16'h0000
`define Z_COMMAND_SET 16'h7F00

// Dataway functions and subaddress
`define F_READ_CTRL 5'h00
`define F_READ_DATA 5'h02
`define F_WRITE_CTRL 5'h10
`define A_CTRL 4'h0

// Data word layout
`define HDR_FLAG_BIT 15
`define HDR_COUNT_LSB 8
`define CHAN_LSB 11
`define OVERFLOW_CODE 11'h7FF

// Timing
`define CLOCK_NS 40
`define COMPRESS_NS 2500
`define COMPRESS_CYCLES ((`COMPRESS_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`define ECL_WORD_NS 100
`define ECL_GAP_CYCLES ((`ECL_WORD_NS + `CLOCK_NS - 1) / `CLOCK_NS)

`endif

// *** inc/adc_readout_pkg.sv ***
// Types shared by the readout-mode control files
package adc_readout_pkg;
    typedef logic [15:0][10:0] chan_values_t;
    typedef logic [15:0][7:0] ped_values_t;
    typedef logic [15:0] word_t;
    typedef enum logic [2:0] {
        ST_READY,
        ST_ECL_COMPRESS,
        ST_ECL_SEND,
        ST_CRATE_COMPRESS,
        ST_CRATE_READ,
        ST_CRATE_EMPTY
    } readout_state_e;
endpackage

// *** inc/chan_cond_if.sv ***
// Channel conditioning signals between the control and the conditioner
`timescale 1ns/10ps
interface chan_cond_if;
    import adc_readout_pkg::*;
    chan_values_t raw;
    ped_values_t ped;
    logic subtract;
    logic zero_sup;
    logic ovf_sup;
    chan_values_t value;
    logic [15:0] keep;
    modport cond (input raw, input ped, input subtract, input zero_sup, input ovf_sup,
                  output value, output keep);
    modport user (output raw, output ped, output subtract, output zero_sup, output ovf_sup,
                  input value, input keep);
endinterface // chan_cond_if

// *** rtl/chan_conditioner.sv ***
// Per-channel pedestal subtraction, clamping and suppression decision
`timescale 1ns/10ps
`include "adc_readout_defines.svh"
module chan_conditioner
    import adc_readout_pkg::*;
(
    // Conditioning bus
    chan_cond_if.cond bus
);
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_chan
            wire logic [11:0] diff;
            wire logic [10:0] clamped;
            wire logic [10:0] chosen;
            wire logic is_zero;
            wire logic is_ovf;
            assign diff = {1'b0, bus.raw[i]} - {4'h0, bus.ped[i]};
            // Negative results are held at zero
            assign clamped = diff[11] ? 11'h000 : diff[10:0];
            assign chosen = bus.subtract ? clamped : bus.raw[i];
            assign is_zero = (chosen == 11'h000);
            assign is_ovf = (bus.raw[i] == `OVERFLOW_CODE);
            assign bus.value[i] = chosen;
            // Keep only values at least 1 and below overflow, each only if asked
            assign bus.keep[i] = !(bus.zero_sup && is_zero) && !(bus.ovf_sup && is_ovf);
        end
    endgenerate
endmodule // chan_conditioner

// *** verification/adc_readout_mode_control_sva.sv ***
// Port checker for the readout-mode control
`timescale 1ns/10ps
`include "adc_readout_defines.svh"
module adc_readout_mode_control_sva (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Dataway
    input wire logic n_in,
    input wire logic [4:0] f_in,
    input wire logic [3:0] a_in,
    input wire logic s1_in,
    input wire logic c_in,
    input wire logic z_in,
    input wire logic q_out,
    input wire logic lam_out,
    // ECL port
    input wire logic [15:0] ecl_data_out,
    input wire logic ecl_strobe_out,
    input wire logic ecl_request_out,
    input wire logic ecl_ack_in
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    wire clr = c_in || z_in;
    wire busy = ecl_request_out || lam_out;
    wire ctrl_fn = (f_in == `F_READ_CTRL) || (f_in == `F_WRITE_CTRL);
    property p_strobe_hold;
        ecl_strobe_out && !ecl_ack_in && !clr |=> ecl_strobe_out && $stable(ecl_data_out);
    endproperty
    a_strobe_hold: assert property (p_strobe_hold) else $error("ECL word dropped");
    property p_strobe_drop;
        ecl_strobe_out && ecl_ack_in |=> !ecl_strobe_out;
    endproperty
    a_strobe_drop: assert property (p_strobe_drop) else $error("strobe kept after ack");
    property p_word_gap;
        $fell(ecl_strobe_out) |-> !ecl_strobe_out [*3];
    endproperty
    a_word_gap: assert property (p_word_gap) else $error("ECL words too close");
    property p_strobe_in_request;
        ecl_strobe_out |-> ecl_request_out;
    endproperty
    a_strobe_in_request: assert property (p_strobe_in_request) else $error("strobe alone");
    property p_clear;
        clr |=> !ecl_request_out && !ecl_strobe_out && !lam_out;
    endproperty
    a_clear: assert property (p_clear) else $error("clear ignored");
    property p_lam_after_ecl;
        lam_out |-> !ecl_request_out;
    endproperty
    a_lam_after_ecl: assert property (p_lam_after_ecl) else $error("LAM during ECL");
    property p_q_cause;
        !$stable(q_out) |-> $past(s1_in) && $past(n_in) && !$past(s1_in, 2);
    endproperty
    a_q_cause: assert property (p_q_cause) else $error("Q moved without access");
    property p_refuse;
        $rose(s1_in) && n_in && a_in == `A_CTRL && ctrl_fn && busy && !clr |=> !q_out;
    endproperty
    a_refuse: assert property (p_refuse) else $error("busy access answered");
    c_ack: cover property (ecl_strobe_out && ecl_ack_in);
    c_lam: cover property ($rose(lam_out));
    c_refuse: cover property ($rose(s1_in) && n_in && busy);
endmodule // adc_readout_mode_control_sva

// *** verification/ecl_receiver_model.sv ***
// ECL-port receiver that acknowledges each word after a set delay
`timescale 1ns/10ps
module ecl_receiver_model (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // ECL port
    input wire logic strobe_in,
    input wire logic [15:0] data_in,
    input wire logic [3:0] delay_in,
    output logic ack_out,
    // Captured words
    output int n_words,
    output logic [15:0] words [0:31]
);
    logic [3:0] wait_cnt;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_out <= 1'b0;
            wait_cnt <= 4'h0;
            n_words <= 0;
        end else if (ack_out) begin
            // Ack lasts one cycle; the word is taken while strobe still stands
            ack_out <= 1'b0;
            wait_cnt <= 4'h0;
            if (strobe_in && n_words < 32) begin
                words[n_words] <= data_in;
                n_words <= n_words + 1;
            end
        end else if (strobe_in) begin
            if (wait_cnt >= delay_in) ack_out <= 1'b1;
            else wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule // ecl_receiver_model

// *** verification/tb_adc_readout_mode_control.sv ***
// Self-checking testbench for the readout-mode control
`timescale 1ns/10ps
`include "adc_readout_defines.svh"
module tb_adc_readout_mode_control;
    import adc_readout_pkg::*;
    logic clock_in = 0, rst_n_in = 0, n_in = 0, s1_in = 0, s2_in = 0, c_in = 0, z_in = 0;
    logic conv_done_in = 0, q_out, lam_out, ecl_strobe_out, ecl_request_out, ecl_ack_in;
    logic [4:0] f_in = 5'h00;
    logic [3:0] a_in = 4'h0;
    logic [3:0] ack_delay = 4'h3;
    word_t w_in = 16'h0000;
    logic [15:0] r_out, ecl_data_out;
    logic [15:0] words [0:31];
    chan_values_t conv_data_in = '0;
    ped_values_t pedestal_in = '0;
    int n_words, n_fail = 0, tests_run = 0;
    always #20 clock_in = ~clock_in;
    adc_readout_mode_control dut (.clock_in, .rst_n_in, .n_in, .f_in, .a_in, .s1_in, .s2_in,
        .c_in, .z_in, .w_in, .r_out, .q_out, .lam_out, .conv_done_in, .conv_data_in,
        .pedestal_in, .ecl_data_out, .ecl_strobe_out, .ecl_request_out, .ecl_ack_in);
    ecl_receiver_model rx (.clock_in, .rst_n_in, .strobe_in(ecl_strobe_out),
        .data_in(ecl_data_out), .delay_in(ack_delay), .ack_out(ecl_ack_in), .n_words, .words);
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One dataway cycle: S1 two cycles, then S2 one cycle
    task automatic dw(input logic [4:0] f, input logic [3:0] a, input word_t w);
        @(posedge clock_in);
        n_in <= 1'b1; f_in <= f; a_in <= a; w_in <= w; s1_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        s1_in <= 1'b0; s2_in <= 1'b1;
        @(posedge clock_in);
        s2_in <= 1'b0;
        @(posedge clock_in);
        n_in <= 1'b0;
    endtask
    // One-cycle pulse: 0 conversion done, 1 clear, 2 initialise
    task automatic pulse(input logic [1:0] which, input chan_values_t raw);
        @(posedge clock_in);
        conv_data_in <= raw;
        if (which == 2'h0) conv_done_in <= 1'b1;
        else if (which == 2'h1) c_in <= 1'b1;
        else z_in <= 1'b1;
        @(posedge clock_in);
        conv_done_in <= 1'b0;
        c_in <= 1'b0;
        z_in <= 1'b0;
    endtask
    task automatic wait_lvl(ref logic sig, input logic lvl, input int lim, output int k);
        for (k = 0; k < lim && sig !== lvl; k++) @(posedge clock_in);
        check({15'h0, sig}, {15'h0, lvl});
    endtask
    task automatic t_plain;
        chan_values_t raw;
        int k, base;
        for (k = 0; k < 16; k++) raw[k] = 11'(2 * k);
        pedestal_in <= {16{8'h07}};
        dw(`F_WRITE_CTRL, `A_CTRL, 16'h55A5);
        check({15'h0, q_out}, 16'h0001);
        dw(`F_READ_CTRL, `A_CTRL, 16'h0000);
        check(r_out, 16'h55A5);
        base = n_words;
        pulse(2'h0, raw);
        wait_lvl(ecl_request_out, 1'b1, 10, k);
        dw(`F_READ_CTRL, `A_CTRL, 16'h0000);
        check({15'h0, q_out}, 16'h0000);
        wait_lvl(ecl_request_out, 1'b0, 400, k);
        check(16'(n_words - base), 16'h0010);
        for (k = 0; k < 16; k++) check(words[base + k], (2 * k > 7) ? 16'(2 * k - 7) : 16'h0);
        wait_lvl(lam_out, 1'b1, 100, k);
        for (k = 0; k < 16; k++) begin
            dw(`F_READ_DATA, 4'(15 - k), 16'h0000);
            check({q_out, r_out[14:0]}, {1'b1, 4'h0, raw[15 - k]});
        end
        pulse(2'h1, raw);
        dw(`F_READ_DATA, 4'h0, 16'h0000);
        check({15'h0, q_out}, 16'h0000);
    endtask
    task automatic t_compress;
        chan_values_t raw = '0;
        int k, base;
        raw[2] = 11'd10;
        raw[3] = `OVERFLOW_CODE;
        raw[6] = 11'd5;
        ack_delay <= 4'h0;
        dw(`F_WRITE_CTRL, `A_CTRL, 16'h80A5);
        pulse(2'h2, raw);
        dw(`F_READ_CTRL, `A_CTRL, 16'h0000);
        check(r_out, 16'hFFA5);
        base = n_words;
        pulse(2'h0, raw);
        wait_lvl(ecl_request_out, 1'b1, 100, k);
        // Request is seen one edge after it rises: pass must span the full 2.5us
        check({15'h0, k * `CLOCK_NS >= `COMPRESS_NS + `CLOCK_NS}, 16'h0001);
        wait_lvl(ecl_request_out, 1'b0, 100, k);
        check(16'(n_words - base), 16'h0002);
        check(words[base], 16'h81A5);
        check(words[base + 1], 16'h1003);
        wait_lvl(lam_out, 1'b1, 100, k);
        dw(`F_READ_DATA, 4'h9, 16'h0000);
        check({q_out, r_out[14:0]}, 16'h81A5);
        dw(`F_READ_DATA, 4'h9, 16'h0000);
        check({q_out, r_out[14:0]}, 16'h9003);
        dw(`F_READ_DATA, 4'h9, 16'h0000);
        check({15'h0, q_out}, 16'h0000);
        pulse(2'h1, raw);
    endtask
    task automatic t_empty;
        chan_values_t raw = '0;
        int k, base;
        base = n_words;
        pulse(2'h0, raw);
        repeat (150) @(posedge clock_in);
        check({lam_out, ecl_request_out, 14'(n_words - base)}, 16'h0000);
        dw(`F_READ_DATA, 4'h0, 16'h0000);
        check({15'h0, q_out}, 16'h0000);
        pulse(2'h1, raw);
        // Data ready with LAM enable clear: LAM must stay low
        dw(`F_WRITE_CTRL, `A_CTRL, 16'h23A5);
        pulse(2'h0, raw);
        repeat (4) @(posedge clock_in);
        dw(`F_READ_DATA, 4'h0, 16'h0000);
        check({15'h0, lam_out}, 16'h0000);
        check({15'h0, q_out}, 16'h0001);
        pulse(2'h1, raw);
        dw(`F_WRITE_CTRL, `A_CTRL, 16'h63A5);
        raw[2] = 11'd10;
        pulse(2'h0, raw);
        wait_lvl(lam_out, 1'b1, 10, k);
        check(16'(n_words - base), 16'h0000);
        for (k = 0; k < 3; k++) begin
            dw(`F_READ_DATA, 4'h7, 16'h0000);
            check({q_out, r_out[14:0]}, {1'b1, 4'h0, raw[k]});
        end
        pulse(2'h1, raw);
    endtask
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #200us;
        n_fail++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
        check({q_out, lam_out, ecl_strobe_out, ecl_request_out, 12'h000}, 16'h0000);
        check(r_out | ecl_data_out, 16'h0000);
        dw(`F_READ_CTRL, `A_CTRL, 16'h0000);
        check(r_out, `CTRL_RESET);
        t_plain();
        t_compress();
        t_empty();
        final_report();
    end
endmodule // tb_adc_readout_mode_control

bind adc_readout_mode_control adc_readout_mode_control_sva u_sva (.clock_in, .rst_n_in, .n_in,
    .f_in, .a_in, .s1_in, .c_in, .z_in, .q_out, .lam_out, .ecl_data_out, .ecl_strobe_out,
    .ecl_request_out, .ecl_ack_in);
